// ### design/pdrs_defines.svh
// Function
// - Internal write cycle ends within 10 ms.
// - Busy writing: release data, never acknowledge.
// - Bytes 0-2 read 80, 08, 07.
// - Bytes 3,4,6,7 read 0D,0B,48,00.
// - Byte 5 reads 02, byte 8 04.
// - Byte 9 by grade: 60,70,70,75.
// - Bytes 10,24: 70 fastest, else 75.
// - Bytes 11-14 read 02,82,08,08.
// - Bytes 15-17 read 01,0E,04.
// - Bytes 18-22 read 0C,01,02,24,C0.
// - Byte 23: 75, slowest grade A0.
// - Bytes 27,29 by grade: 48,3C,50,50.
// - Byte 28: 30 fastest, else 3C.
// - Select byte 1010, straps, rw; match straps.
// - Acknowledge select byte; in write, each byte.
// - Read continues while acknowledged; nack stops.
// - Stop ends transfer; standby until start.
`ifndef PDRS_DEFINES_SVH
`define PDRS_DEFINES_SVH

`define PDRS_CLK_PERIOD_PS     5000
`define PDRS_WRITE_CYCLE_MS    10
`define PDRS_WRITE_CYCLE_CYC   ((`PDRS_WRITE_CYCLE_MS * 64'd1000000000) / `PDRS_CLK_PERIOD_PS)
`define PDRS_DEV_TYPE          4'hA
`define PDRS_TABLE_BYTES       30
`define PDRS_ADDR_W            8

`endif

// ### design/pdrs_pkg.sv
package pdrs_pkg;
    typedef enum logic [2:0] {
        PDRS_IDLE,
        PDRS_DEV,
        PDRS_WADDR,
        PDRS_WDATA,
        PDRS_RDATA,
        PDRS_ACK,
        PDRS_RACK,
        PDRS_WAIT
    } pdrs_state_t;

    typedef struct packed {
        logic scl;
        logic sda;
    } pdrs_bus_t;
endpackage

// ### design/pdrs_slave.sv
`timescale 1ns/1ps
`include "pdrs_defines.svh"

module pdrs_slave #(
    parameter int unsigned WRITE_CYCLES = 32'(`PDRS_WRITE_CYCLE_CYC)
) (
    input  wire logic       clk,           // 200 MHz sampling clock
    input  wire logic       rst,           // Synchronous reset, active high
    input  wire logic       scl_in,        // Serial clock from controller
    input  wire logic       sda_in,        // Serial data line level
    output logic            sda_out,       // Serial data drive value, always low
    output logic            sda_oe_n,      // Low while the line is pulled low
    input  wire logic       strap_addr_bit0, // Strap address bit 0
    input  wire logic       strap_addr_bit1, // Strap address bit 1
    input  wire logic       strap_addr_bit2, // Strap address bit 2
    input  wire logic [1:0] speed_grade,   // 0 fastest to 3 slowest
    output logic            write_busy     // Internal write cycle running
);
    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [2:0] scl_sync;
    logic [2:0] sda_sync;
    logic       scl_q;
    logic       sda_q;
    logic [2:0] next_scl_sync;
    logic [2:0] next_sda_sync;
    logic       next_scl_q;
    logic       next_sda_q;

    always_comb
    begin
        next_scl_sync = {scl_sync[1:0], scl_in};
        next_sda_sync = {sda_sync[1:0], sda_in};
        // A change counts once the second and third stages agree.
        next_scl_q = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_q;
        next_sda_q = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_q;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            scl_sync <= 3'h7;
            sda_sync <= 3'h7;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end
        else
        begin
            scl_sync <= next_scl_sync;
            sda_sync <= next_sda_sync;
            scl_q    <= next_scl_q;
            sda_q    <= next_sda_q;
        end
    end

    pdrs_pkg::pdrs_bus_t cur;
    pdrs_pkg::pdrs_bus_t prev;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign cur.scl    = scl_q;
    assign cur.sda    = sda_q;
    assign scl_rise   = cur.scl & ~prev.scl;
    assign scl_fall   = ~cur.scl & prev.scl;
    assign start_cond = cur.scl & prev.scl & prev.sda & ~cur.sda;
    assign stop_cond  = cur.scl & prev.scl & ~prev.sda & cur.sda;

    // ------------------------------------------------------------
    // Table contents
    // ------------------------------------------------------------
    function automatic logic [7:0] table_byte(input logic [7:0] a, input logic [1:0] g);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            8'h00: v = 8'h80;
            8'h01: v = 8'h08;
            8'h02: v = 8'h07;
            8'h03: v = 8'h0D;
            8'h04: v = 8'h0B;
            8'h05: v = 8'h02;
            8'h06: v = 8'h48;
            8'h07: v = 8'h00;
            8'h08: v = 8'h04;
            8'h09: v = (g == 2'h0) ? 8'h60 : (g == 2'h3) ? 8'h75 : 8'h70;
            8'h0A, 8'h18: v = (g == 2'h0) ? 8'h70 : 8'h75;
            8'h0B: v = 8'h02;
            8'h0C: v = 8'h82;
            8'h0D, 8'h0E: v = 8'h08;
            8'h0F: v = 8'h01;
            8'h10: v = 8'h0E;
            8'h11: v = 8'h04;
            8'h12: v = 8'h0C;
            8'h13: v = 8'h01;
            8'h14: v = 8'h02;
            8'h15: v = 8'h24;
            8'h16: v = 8'hC0;
            8'h17: v = (g == 2'h3) ? 8'hA0 : 8'h75;
            8'h19, 8'h1A: v = 8'h00;
            8'h1B, 8'h1D: v = (g == 2'h0) ? 8'h48 : (g == 2'h1) ? 8'h3C : 8'h50;
            8'h1C: v = (g == 2'h0) ? 8'h30 : 8'h3C;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------
    // Protocol engine
    // ------------------------------------------------------------
    pdrs_pkg::pdrs_state_t state;
    pdrs_pkg::pdrs_state_t next_state;
    pdrs_pkg::pdrs_state_t after_ack;
    pdrs_pkg::pdrs_state_t next_after_ack;
    logic [7:0]  shreg;
    logic [7:0]  next_shreg;
    logic [3:0]  bitcnt;
    logic [3:0]  next_bitcnt;
    logic [7:0]  addr;
    logic [7:0]  next_addr;
    logic        drive_low;
    logic        next_drive_low;
    logic        wrote;
    logic        next_wrote;
    logic [31:0] busy_cnt;
    logic [31:0] next_busy_cnt;
    logic        next_write_busy;
    logic [7:0]  strap_sel;

    assign strap_sel = {`PDRS_DEV_TYPE, strap_addr_bit2, strap_addr_bit1, strap_addr_bit0, 1'b0};

    always_comb
    begin
        next_state      = state;
        next_after_ack  = after_ack;
        next_shreg      = shreg;
        next_bitcnt     = bitcnt;
        next_addr       = addr;
        next_drive_low  = drive_low;
        next_wrote      = wrote;
        next_busy_cnt   = busy_cnt;
        next_write_busy = write_busy;
        if (write_busy)
        begin
            // The bus is ignored entirely until the program cycle completes.
            next_state     = pdrs_pkg::PDRS_IDLE;
            next_drive_low = 1'b0;
            if (busy_cnt >= WRITE_CYCLES - 1)
            begin
                next_write_busy = 1'b0;
                next_busy_cnt   = 32'h0;
            end
            else
                next_busy_cnt = busy_cnt + 32'h1;
        end
        else if (stop_cond)
        begin
            next_state     = pdrs_pkg::PDRS_IDLE;
            next_drive_low = 1'b0;
            next_wrote     = 1'b0;
            next_write_busy = wrote;
            next_busy_cnt  = 32'h0;
        end
        else if (start_cond)
        begin
            next_state     = pdrs_pkg::PDRS_DEV;
            next_bitcnt    = 4'h0;
            next_drive_low = 1'b0;
        end
        else
        begin
            case (state)
                pdrs_pkg::PDRS_DEV, pdrs_pkg::PDRS_WADDR, pdrs_pkg::PDRS_WDATA:
                begin
                    if (scl_rise)
                    begin
                        next_shreg  = {shreg[6:0], cur.sda};
                        next_bitcnt = bitcnt + 4'h1;
                    end
                    if (scl_fall && bitcnt == 4'h8)
                    begin
                        next_bitcnt = 4'h0;
                        if (state == pdrs_pkg::PDRS_DEV)
                        begin
                            if (shreg[7:1] == strap_sel[7:1])
                            begin
                                next_drive_low = 1'b1;
                                next_state     = pdrs_pkg::PDRS_ACK;
                                next_after_ack = shreg[0] ? pdrs_pkg::PDRS_RACK
                                                          : pdrs_pkg::PDRS_WADDR;
                            end
                            else
                                next_state = pdrs_pkg::PDRS_WAIT;
                        end
                        else
                        begin
                            next_drive_low = 1'b1;
                            next_state     = pdrs_pkg::PDRS_ACK;
                            next_after_ack = pdrs_pkg::PDRS_WDATA;
                            if (state == pdrs_pkg::PDRS_WADDR)
                                next_addr = shreg;
                            else
                            begin
                                // The table is fixed, so a written byte only moves the address and marks a write cycle for the next stop.
                                next_addr  = addr + 8'h1;
                                next_wrote = 1'b1;
                            end
                        end
                    end
                end
                pdrs_pkg::PDRS_ACK:
                begin
                    if (scl_fall)
                    begin
                        if (after_ack == pdrs_pkg::PDRS_RACK)
                        begin
                            next_shreg     = table_byte(addr, speed_grade);
                            next_drive_low = ~next_shreg[7];
                            next_bitcnt    = 4'h1;
                            next_state     = pdrs_pkg::PDRS_RDATA;
                        end
                        else
                        begin
                            next_drive_low = 1'b0;
                            next_state     = after_ack;
                        end
                    end
                end
                pdrs_pkg::PDRS_RDATA:
                begin
                    if (scl_fall)
                    begin
                        if (bitcnt == 4'h8)
                        begin
                            next_drive_low = 1'b0;
                            next_bitcnt    = 4'h0;
                            next_addr      = addr + 8'h1;
                            next_state     = pdrs_pkg::PDRS_RACK;
                        end
                        else
                        begin
                            next_drive_low = ~shreg[6];
                            next_shreg     = {shreg[6:0], 1'b0};
                            next_bitcnt    = bitcnt + 4'h1;
                        end
                    end
                end
                pdrs_pkg::PDRS_RACK:
                begin
                    if (scl_rise)
                    begin
                        if (cur.sda)
                            next_state = pdrs_pkg::PDRS_WAIT;
                        else
                            next_state = pdrs_pkg::PDRS_ACK;
                        next_after_ack = pdrs_pkg::PDRS_RACK;
                    end
                end
                pdrs_pkg::PDRS_IDLE, pdrs_pkg::PDRS_WAIT: next_drive_low = 1'b0;
                default: next_state = pdrs_pkg::PDRS_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            prev       <= '{scl: 1'b1, sda: 1'b1};
            state      <= pdrs_pkg::PDRS_IDLE;
            after_ack  <= pdrs_pkg::PDRS_IDLE;
            shreg      <= 8'h00;
            bitcnt     <= 4'h0;
            addr       <= 8'h00;
            drive_low  <= 1'b0;
            wrote      <= 1'b0;
            busy_cnt   <= 32'h0;
            write_busy <= 1'b0;
        end
        else
        begin
            prev       <= cur;
            state      <= next_state;
            after_ack  <= next_after_ack;
            shreg      <= next_shreg;
            bitcnt     <= next_bitcnt;
            addr       <= next_addr;
            drive_low  <= next_drive_low;
            wrote      <= next_wrote;
            busy_cnt   <= next_busy_cnt;
            write_busy <= next_write_busy;
        end
    end

    assign sda_out  = 1'b0;
    assign sda_oe_n = ~drive_low;
endmodule

// ### tb/pdrs_slave_monitor.sv
`timescale 1ns/1ps

module pdrs_slave_monitor #(
    parameter int unsigned WRITE_CYCLES = 50
) (
    input wire logic clk,        // Sampling clock
    input wire logic rst,        // Synchronous reset
    input wire logic scl_in,     // Serial clock level
    input wire logic sda_in,     // Resolved data line
    input wire logic sda_out,    // Data drive value
    input wire logic sda_oe_n,   // Low while the device pulls low
    input wire logic write_busy  // Internal write cycle running
);
    default clocking mon_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // Busy length counter
    // ------------------------------------------------------------
    logic [31:0] busy_cnt;
    logic [31:0] next_busy_cnt;

    always_comb
    begin
        next_busy_cnt = (rst || !write_busy) ? 32'h0 : busy_cnt + 32'h1;
    end

    always_ff @(posedge clk)
    begin
        busy_cnt <= next_busy_cnt;
    end

    AST_BUSY_CAP: assert property (busy_cnt <= WRITE_CYCLES)
        else $error("write cycle ran past its bound");
    AST_BUSY_LEN: assert property ($fell(write_busy) |-> busy_cnt + 1 >= WRITE_CYCLES)
        else $error("write cycle ended early");
    AST_BUSY_AFTER_STOP: assert property ($rose(write_busy) |-> scl_in && sda_in)
        else $error("write cycle began without a stop");
    AST_BUSY_RELEASE: assert property (write_busy |-> sda_oe_n)
        else $error("line pulled while busy");
    AST_PULL_LOW_ONLY: assert property (sda_out == 1'b0)
        else $error("drive value not low");
    AST_DRIVE_SCL_LOW: assert property ($fell(sda_oe_n) |-> !scl_in)
        else $error("drive began while clock high");
    AST_STEADY_SCL_HIGH: assert property (
        scl_in && $past(scl_in, 4) |-> $stable(sda_oe_n))
        else $error("drive changed while clock high");
    AST_STOP_STANDBY: assert property (
        scl_in && $past(scl_in) && $rose(sda_in) |-> ##1 sda_oe_n [*8])
        else $error("line pulled after stop");

    COV_BUSY: cover property ($rose(write_busy));
    COV_ACK: cover property ($fell(sda_oe_n));
    COV_STOP: cover property (scl_in && $rose(sda_in));
endmodule

bind pdrs_slave pdrs_slave_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) pdrs_slave_monitor_inst (
    .clk(clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .write_busy(write_busy));

// ### tb/pdrs_host_model.sv
`timescale 1ns/1ps

module pdrs_host_model (
    input  wire logic clk,      // Sampling clock
    output logic      scl,      // Serial clock, still between frames
    output logic      sda_drv,  // High releases the data line
    input  wire logic sda_line  // Resolved data line
);
    // ------------------------------------------------------------
    // Bus cycles, 16 clocks per serial bit
    // ------------------------------------------------------------
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic start_cond();
        sda_drv <= 1'b1;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(8);
        sda_drv <= 1'b0;
        wait_clk(8);
        scl <= 1'b0;
        wait_clk(4);
    endtask

    task automatic stop_cond();
        sda_drv <= 1'b0;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(8);
        sda_drv <= 1'b1;
        wait_clk(8);
    endtask

    task automatic xbit(input logic b, output logic seen);
        sda_drv <= b;
        wait_clk(4);
        scl <= 1'b1;
        wait_clk(8);
        seen = sda_line;
        scl <= 1'b0;
        wait_clk(4);
    endtask

    // Sends a byte most significant bit first, then the ninth bit.
    task automatic xbyte(input logic [7:0] tx, input logic ack_out,
                         output logic [7:0] rx, output logic ack_in);
        for (int i = 7; i >= 0; i--)
            xbit(tx[i], rx[i]);
        xbit(ack_out, ack_in);
    endtask
endmodule

// ### tb/pdrs_slave_tb.sv
`timescale 1ns/1ps

module pdrs_slave_tb;
    // ------------------------------------------------------------
    // Bench state
    // ------------------------------------------------------------
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic [1:0] speed_grade = 2'h0;
    logic [2:0] strap = 3'h5;
    logic       scl;
    logic       sda_drv;
    logic       sda_out;
    logic       sda_oe_n;
    logic       write_busy;
    wire        sda_line = sda_drv & (sda_oe_n | sda_out);
    int         err_count = 0;
    int         checked = 0;
    logic [7:0] fixed_bytes [0:30] = '{8'h80, 8'h08, 8'h07, 8'h0D, 8'h0B, 8'h02, 8'h48, 8'h00,
        8'h04, 8'h00, 8'h00, 8'h02, 8'h82, 8'h08, 8'h08, 8'h01, 8'h0E, 8'h04, 8'h0C, 8'h01,
        8'h02, 8'h24, 8'hC0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    always #2.5 clk = ~clk;

    pdrs_host_model pdrs_host_model_inst (.clk(clk), .scl(scl), .sda_drv(sda_drv),
        .sda_line(sda_line));

    // A short write cycle keeps the run brief while still outlasting one refused select.
    pdrs_slave #(.WRITE_CYCLES(400)) pdrs_slave_inst (.clk(clk), .rst(rst), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .strap_addr_bit0(strap[0]), .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]),
        .speed_grade(speed_grade), .write_busy(write_busy));

    function automatic logic [7:0] exp_byte(input logic [1:0] g, input int i);
        case (i)
            9:       return (g == 2'h0) ? 8'h60 : (g == 2'h3) ? 8'h75 : 8'h70;
            10, 24:  return (g == 2'h0) ? 8'h70 : 8'h75;
            23:      return (g == 2'h3) ? 8'hA0 : 8'h75;
            27, 29:  return (g == 2'h0) ? 8'h48 : (g == 2'h1) ? 8'h3C : 8'h50;
            28:      return (g == 2'h0) ? 8'h30 : 8'h3C;
            default: return fixed_bytes[i];
        endcase
    endfunction

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
            err_count++;
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic select(input logic [3:0] kind, input logic [2:0] s, input logic rw,
                          input logic [7:0] exp_ack);
        logic [7:0] rx;
        logic       ack;
        pdrs_host_model_inst.start_cond();
        pdrs_host_model_inst.xbyte({kind, s, rw}, 1'b1, rx, ack);
        check("select ack", {7'h0, ack}, exp_ack);
    endtask

    task automatic read_grade(input logic [1:0] g);
        logic [7:0] rx;
        logic       ack;
        speed_grade <= g;
        select(4'hA, strap, 1'b0, 8'h00);
        pdrs_host_model_inst.xbyte(8'h00, 1'b1, rx, ack);
        check("address ack", {7'h0, ack}, 8'h00);
        select(4'hA, strap, 1'b1, 8'h00);
        for (int i = 0; i < 31; i++)
        begin
            pdrs_host_model_inst.xbyte(8'hFF, i == 30, rx, ack);
            check("table byte", rx, exp_byte(g, i));
        end
        pdrs_host_model_inst.stop_cond();
    endtask

    task automatic wrong_select();
        select(4'hA, ~strap, 1'b1, 8'h01);
        select(4'h6, strap, 1'b1, 8'h01);
        pdrs_host_model_inst.stop_cond();
    endtask

    task automatic write_then_read();
        logic [7:0] rx;
        logic       ack;
        int         n;
        select(4'hA, strap, 1'b0, 8'h00);
        pdrs_host_model_inst.xbyte(8'h05, 1'b1, rx, ack);
        pdrs_host_model_inst.xbyte(8'h55, 1'b1, rx, ack);
        check("data ack", {7'h0, ack}, 8'h00);
        pdrs_host_model_inst.stop_cond();
        check("busy", {7'h0, write_busy}, 8'h01);
        select(4'hA, strap, 1'b1, 8'h01);
        pdrs_host_model_inst.stop_cond();
        n = 0;
        while (write_busy !== 1'b0 && n < 600)
        begin
            @(posedge clk);
            n++;
        end
        check("busy end", {7'h0, write_busy}, 8'h00);
        if (n == 600)
            give_verdict();
        select(4'hA, strap, 1'b1, 8'h00);
        pdrs_host_model_inst.xbyte(8'hFF, 1'b1, rx, ack);
        check("current byte", rx, 8'h48);
        pdrs_host_model_inst.xbyte(8'hFF, 1'b1, rx, ack);
        check("after no ack", rx, 8'hFF);
        pdrs_host_model_inst.stop_cond();
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        for (int g = 0; g < 4; g++)
            read_grade(g[1:0]);
        wrong_select();
        write_then_read();
        give_verdict();
    end
endmodule
